/* File: hdl/asu_pkg.sv */
// package: constants, types and helpers shared by the async serial unit
package asu_pkg;

  localparam int NUNIT = 2;
  localparam int DIV_W = 13;
  localparam int DW    = 9;
  localparam int AW    = 6;
  localparam int EVT_W = 7;
  localparam int UNIT_BIT = 5;

  // oversampling: sixteen ticks per bit, three votes around mid-bit
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SMP_A    = 4'h7;
  localparam logic [3:0] SMP_B    = 4'h8;
  localparam logic [3:0] SMP_C    = 4'h9;

  // frame lengths in bits including start and stop, and the bit index of the stop bit
  localparam logic [3:0] FRAME8 = 4'hA;
  localparam logic [3:0] FRAME9 = 4'hB;
  localparam logic [3:0] STOP8  = 4'h9;
  localparam logic [3:0] STOP9  = 4'hA;

  // per-unit register byte offsets; address bit 5 picks the unit
  localparam logic [4:0] OFF_BAUD = 5'h00;
  localparam logic [4:0] OFF_CTRL = 5'h04;
  localparam logic [4:0] OFF_DATA = 5'h08;
  localparam logic [4:0] OFF_STAT = 5'h0C;
  localparam logic [4:0] OFF_MASK = 5'h10;

  localparam logic [DW-1:0] MASK8 = 9'h07F;
  localparam logic [DW-1:0] MASK9 = 9'h0FF;

  typedef enum logic {RX_IDLE, RX_FRAME} asu_rxst_t;

  typedef struct packed {
    logic wake;
    logic par_odd;
    logic par_en;
    logic nine;
    logic re;
    logic te;
  } asu_ctrl_t;

  typedef struct packed {
    logic pf;
    logic fe;
    logic nf;
    logic ovr;
    logic rdrf;
    logic tc;
    logic tdre;
  } asu_evt_t;

  typedef struct packed {
    logic rdrf;
    logic tc;
    logic tdre;
  } asu_lvl_t;

  typedef struct packed {
    logic [DIV_W-1:0] baud;
    asu_ctrl_t        ctrl;
    asu_evt_t         evt;
    asu_evt_t         mask;
    logic [DW-1:0]    rxbuf;
    logic             rdrf;
    asu_rxst_t        st;
    logic [3:0]       ph;
    logic [3:0]       idx;
    logic [2:0]       smp;
    logic [DW-1:0]    sr;
    logic             noisy;
  } asu_unit_t;

  // parity over the data bits below the parity slot
  function automatic logic asu_parity(logic [DW-1:0] d, logic nine,
                                      logic odd);
    logic [DW-1:0] m;
    m = nine ? MASK9 : MASK8;
    return (^(d & m)) ^ odd;
  endfunction

endpackage

/* File: hdl/asu_baud.sv */
// 16x sample tick generator with a 13-bit modulo divider
`timescale 1ns/1ns
module asu_baud (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  // divider setting and tick
  input  wire logic [asu_pkg::DIV_W-1:0] div,
  output logic                           tick
);
  logic [asu_pkg::DIV_W-1:0] cnt;
  logic [asu_pkg::DIV_W-1:0] next_cnt;
  logic                      next_tick;

  always_comb begin
    next_cnt  = cnt + 13'h0001;
    next_tick = 1'b0;
    if (div == 13'h0000) begin
      next_cnt = 13'h0000;
    end else if (cnt >= div - 13'h0001) begin
      next_cnt  = 13'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt  <= 13'h0000;
      tick <= 1'b0;
    end else if (ce) begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule // asu_baud

/* File: hdl/asu_tx.sv */
// double-buffered transmitter: holding register feeding a shifter
`timescale 1ns/1ns
module asu_tx (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // configuration
  input  wire logic                   tick,
  input  wire logic                   en,
  input  wire logic                   nine,
  input  wire logic                   par_en,
  input  wire logic                   par_odd,
  // holding register load
  input  wire logic                   wr,
  input  wire logic [asu_pkg::DW-1:0] wdata,
  // line and status
  output logic                        txd,
  output logic                        tdre,
  output logic                        tc,
  output logic                        tdre_ev,
  output logic                        tc_ev
);
  logic [asu_pkg::DW-1:0] hold, next_hold;
  logic                   full, next_full;
  logic [10:0]            sh, next_sh;
  logic [3:0]             left, next_left;
  logic [3:0]             ph, next_ph;
  logic                   busy, next_busy;
  logic                   next_txd, next_tdre_ev, next_tc_ev;
  logic [asu_pkg::DW-1:0] pay;
  logic                   done;

  always_comb begin
    next_hold    = hold;
    next_full    = full;
    next_sh      = sh;
    next_left    = left;
    next_ph      = ph;
    next_busy    = busy;
    next_tdre_ev = 1'b0;
    next_tc_ev   = 1'b0;
    done         = 1'b0;
    pay          = hold;
    if (busy && tick) begin
      next_ph = ph + 4'h1;
      if (ph == asu_pkg::OVS_LAST) begin
        next_sh   = {1'b1, sh[10:1]};
        next_left = left - 4'h1;
        if (left == 4'h1) begin
          done      = 1'b1;
          next_busy = 1'b0;
        end
      end
    end
    // next character follows the stop bit with no gap
    if ((!busy || done) && full && en) begin
      if (par_en) begin
        if (nine) begin
          pay[8] = asu_pkg::asu_parity(hold, nine, par_odd);
        end else begin
          pay[7] = asu_pkg::asu_parity(hold, nine, par_odd);
        end
      end
      next_sh      = nine ? {1'b1, pay, 1'b0}
                          : {2'b11, pay[7:0], 1'b0};
      next_left    = nine ? asu_pkg::FRAME9 : asu_pkg::FRAME8;
      next_ph      = 4'h0;
      next_busy    = 1'b1;
      next_full    = 1'b0;
      next_tdre_ev = 1'b1;
    end else if (done) begin
      next_tc_ev = 1'b1;
    end
    if (wr) begin
      next_hold = wdata;
      next_full = 1'b1;
    end
    next_txd = next_busy ? next_sh[0] : 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold    <= '0;
      full    <= 1'b0;
      sh      <= '1;
      left    <= 4'h0;
      ph      <= 4'h0;
      busy    <= 1'b0;
      txd     <= 1'b1;
      tdre_ev <= 1'b0;
      tc_ev   <= 1'b0;
    end else if (ce) begin
      hold    <= next_hold;
      full    <= next_full;
      sh      <= next_sh;
      left    <= next_left;
      ph      <= next_ph;
      busy    <= next_busy;
      txd     <= next_txd;
      tdre_ev <= next_tdre_ev;
      tc_ev   <= next_tc_ev;
    end
  end

  assign tdre = !full;
  assign tc   = !full && !busy;
endmodule // asu_tx

/* File: hdl/asu_top.sv */
// two async serial units behind one avalon-mm register slave
// Summary of operation
// - 13-bit modulo divider sets each bit rate
// - transmitter and receiver share one divider
// - two units, each with own divider
// - nrz line, transmit and receive simultaneously
// - double buffers with separate transmit, receive enables
// - tdre and tc flags, polled or interrupting
// - three samples per bit, disagreement flags noise
// - parity generate and check; address-mark wakeup
`timescale 1ns/1ns
module asu_top (
  // clock, reset, clock enable
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // avalon-mm register slave
  input  wire logic [asu_pkg::AW-1:0]   avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  // serial lines, one per unit
  input  wire logic [asu_pkg::NUNIT-1:0] ser_rxd,
  output logic      [asu_pkg::NUNIT-1:0] ser_txd,
  // interrupt
  output logic                          irq
);
  // bus handshake: one wait cycle, then the access completes
  logic        ack, next_ack;
  logic [31:0] next_rdata;
  logic        req;
  logic        acc;
  logic        sel_unit;
  logic [4:0]  off;
  logic [31:0] rd_word [asu_pkg::NUNIT];
  logic [asu_pkg::NUNIT-1:0] irq_u;

  assign req             = avs_read || avs_write;
  assign acc             = req && ack;
  // a frozen cycle must not complete an access that the flops never see
  assign avs_waitrequest = req && !(ack && ce);
  assign sel_unit        = avs_address[asu_pkg::UNIT_BIT];
  assign off             = avs_address[4:0];

  always_comb begin
    next_ack   = req && !ack;
    next_rdata = avs_readdata;
    if (avs_read && !ack) begin
      next_rdata = rd_word[sel_unit];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (ce) begin
      ack          <= next_ack;
      avs_readdata <= next_rdata;
    end
  end

  assign irq = |irq_u;

  for (genvar g = 0; g < asu_pkg::NUNIT; g++) begin : g_unit
    asu_pkg::asu_unit_t u, n;
    asu_pkg::asu_evt_t  set, clr;
    asu_pkg::asu_lvl_t  lvl;
    logic [1:0]         sync;
    logic               rx_bit;
    logic               tick;
    logic               hit;
    logic               wr_baud, wr_ctrl, wr_data, wr_stat, wr_mask;
    logic               rd_data;
    logic               tdre, tc, tdre_ev, tc_ev;
    logic               vote, nz, top;
    logic [asu_pkg::DW-1:0] data;
    logic [31:0]            word;

    assign hit     = acc && (sel_unit == 1'(g));
    assign wr_baud = hit && avs_write && off == asu_pkg::OFF_BAUD;
    assign wr_ctrl = hit && avs_write && off == asu_pkg::OFF_CTRL;
    assign wr_data = hit && avs_write && off == asu_pkg::OFF_DATA;
    assign wr_stat = hit && avs_write && off == asu_pkg::OFF_STAT;
    assign wr_mask = hit && avs_write && off == asu_pkg::OFF_MASK;
    assign rd_data = hit && avs_read && off == asu_pkg::OFF_DATA;

    // one divider feeds both directions of this unit
    asu_baud u_baud (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .div      (u.baud),
      .tick     (tick)
    );

    asu_tx u_tx (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .tick     (tick),
      .en       (u.ctrl.te),
      .nine     (u.ctrl.nine),
      .par_en   (u.ctrl.par_en),
      .par_odd  (u.ctrl.par_odd),
      .wr       (wr_data),
      .wdata    (avs_writedata[asu_pkg::DW-1:0]),
      .txd      (ser_txd[g]),
      .tdre     (tdre),
      .tc       (tc),
      .tdre_ev  (tdre_ev),
      .tc_ev    (tc_ev)
    );

    // line input crosses into the clock domain through two flops
    always_ff @(posedge core_clk) begin
      if (rst) begin
        sync <= 2'h3;
      end else if (ce) begin
        sync <= {sync[0], ser_rxd[g]};
      end
    end
    assign rx_bit = sync[1];

    assign lvl.rdrf = u.rdrf;
    assign lvl.tc   = tc;
    assign lvl.tdre = tdre;

    // one local word per unit keeps each array element to one driver
    always_comb begin
      word = 32'h0000_0000;
      unique case (off)
        asu_pkg::OFF_BAUD: word = {19'h0, u.baud};
        asu_pkg::OFF_CTRL: word = {26'h0, u.ctrl};
        asu_pkg::OFF_DATA: word = {23'h0, u.rxbuf};
        asu_pkg::OFF_STAT: word = {21'h0, lvl, 1'b0, u.evt};
        asu_pkg::OFF_MASK: word = {25'h0, u.mask};
        default:           word = 32'h0000_0000;
      endcase
    end
    assign rd_word[g] = word;

    assign irq_u[g] = |(u.evt & u.mask);

    always_comb begin
      n    = u;
      set  = '0;
      clr  = '0;
      vote = (u.smp[0] & u.smp[1]) | (u.smp[0] & u.smp[2])
           | (u.smp[1] & u.smp[2]);
      nz   = !(&u.smp) && (|u.smp);
      data = u.ctrl.nine ? u.sr : {1'b0, u.sr[8:1]};
      top  = u.ctrl.nine ? data[8] : data[7];
      set.tdre = tdre_ev;
      set.tc   = tc_ev;
      if (rd_data) begin
        n.rdrf = 1'b0;
      end
      if (!u.ctrl.re) begin
        n.st = asu_pkg::RX_IDLE;
      end else if (tick) begin
        if (u.st == asu_pkg::RX_IDLE) begin
          if (!rx_bit) begin
            n.st    = asu_pkg::RX_FRAME;
            n.ph    = 4'h1;
            n.idx   = 4'h0;
            n.smp   = 3'h0;
            n.noisy = 1'b0;
          end
        end else begin
          n.ph = u.ph + 4'h1;
          if (u.ph == asu_pkg::SMP_A || u.ph == asu_pkg::SMP_B
              || u.ph == asu_pkg::SMP_C) begin
            n.smp = {u.smp[1:0], rx_bit};
          end
          if (u.ph == asu_pkg::OVS_LAST) begin
            n.idx   = u.idx + 4'h1;
            n.noisy = u.noisy | nz;
            if (u.idx == 4'h0) begin
              if (vote) begin
                n.st = asu_pkg::RX_IDLE; // glitch, not a start bit
              end
            end else if (u.idx == (u.ctrl.nine ? asu_pkg::STOP9
                                                : asu_pkg::STOP8)) begin
              n.st = asu_pkg::RX_IDLE;
              // asleep: only an address-marked character wakes it
              if (!u.ctrl.wake || top) begin
                n.ctrl.wake = 1'b0;
                if (u.rdrf && !rd_data) begin
                  set.ovr = 1'b1;
                end else begin
                  n.rxbuf  = data;
                  n.rdrf   = 1'b1;
                  set.rdrf = 1'b1;
                  set.fe   = !vote;
                  set.nf   = u.noisy | nz;
                  set.pf   = u.ctrl.par_en && (top != asu_pkg::asu_parity(
                               data, u.ctrl.nine, u.ctrl.par_odd));
                end
              end
            end else begin
              n.sr = {vote, u.sr[8:1]};
            end
          end
        end
      end
      if (wr_baud) begin
        n.baud = avs_writedata[asu_pkg::DIV_W-1:0];
      end
      if (wr_ctrl) begin
        n.ctrl = avs_writedata[5:0];
      end
      if (wr_mask) begin
        n.mask = avs_writedata[asu_pkg::EVT_W-1:0];
      end
      if (wr_stat) begin
        clr = avs_writedata[asu_pkg::EVT_W-1:0];
      end
      // a new event beats a clear in the same cycle
      n.evt = (u.evt & ~clr) | set;
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        u <= '0;
      end else if (ce) begin
        u <= n;
      end
    end
  end
endmodule // asu_top

/* File: tb/asu_line_model.sv */
// line-side peer: captures frames from txd and sends frames on rxd
`timescale 1ns/1ns
module asu_line_model #(
  parameter int BIT = 32
) (
  // clock
  input  wire logic core_clk,
  // line
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got;
  int         n_got;
  initial begin
    rxd = 1'b1;
    n_got = 0;
  end
  // mid-bit sampling; a low stop bit is not counted as a frame
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge core_clk);
      got[i] = txd;
    end
    repeat (BIT) @(posedge core_clk);
    if (txd) n_got++;
  end
  // glitch covers one of the three votes only, so noise not data is seen
  task automatic send(input logic [7:0] d, input logic bad, input logic gl);
    @(posedge core_clk);
    rxd <= 1'b0;
    repeat (BIT) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= d[i];
      if (gl && i == 0) begin
        repeat (16) @(posedge core_clk);
        rxd <= ~d[i];
        repeat (2) @(posedge core_clk);
        rxd <= d[i];
        repeat (BIT - 18) @(posedge core_clk);
      end else repeat (BIT) @(posedge core_clk);
    end
    rxd <= ~bad;
    repeat (BIT) @(posedge core_clk);
    rxd <= 1'b1;
  endtask
endmodule // asu_line_model

/* File: tb/asu_top_monitor.sv */
// checker: bus handshake and line timing of the serial block
`timescale 1ns/1ns
module asu_top_monitor (
  // clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst,
  input wire logic                      ce,
  // bus
  input wire logic                      avs_read,
  input wire logic                      avs_write,
  input wire logic [31:0]               avs_readdata,
  input wire logic                      avs_waitrequest,
  // line and interrupt
  input wire logic [asu_pkg::NUNIT-1:0] ser_txd,
  input wire logic                      irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic req;
  assign req = avs_read || avs_write;
  wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("request answered without a wait cycle");
  ans_next_a: assert property (req && avs_waitrequest && ce
    |=> !avs_waitrequest)
    else $error("answer late");
  idle_wait_a: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  rdata_hold_a: assert property ($changed(avs_readdata)
    |-> avs_read && !avs_waitrequest)
    else $error("read data moved outside a read answer");
  txd_idle_a: assert property ($past(rst) |-> &ser_txd)
    else $error("line not idle high after reset");
  start_len_a: assert property ($fell(ser_txd[0])
    |-> (!ser_txd[0]) [*8])
    else $error("low bit too short");
  bit_hold0_a: assert property ($changed(ser_txd[0])
    |=> $stable(ser_txd[0]) [*8])
    else $error("unit 0 bit too short");
  bit_hold1_a: assert property ($changed(ser_txd[1])
    |=> $stable(ser_txd[1]) [*8])
    else $error("unit 1 bit too short");
  cover property ($rose(irq));
  cover property ($fell(ser_txd[0]));
  cover property (avs_read && !avs_waitrequest);
endmodule // asu_top_monitor
bind asu_top asu_top_monitor u_mon (.core_clk(core_clk), .rst(rst), .ce(ce),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ser_txd(ser_txd), .irq(irq));

/* File: tb/test_async_serial_transceiver.sv */
// bench: register tasks, line peers and checks of the serial block
`timescale 1ns/1ns
module test_async_serial_transceiver;
  localparam logic [4:0] BD = asu_pkg::OFF_BAUD;
  localparam logic [4:0] CT = asu_pkg::OFF_CTRL;
  localparam logic [4:0] DA = asu_pkg::OFF_DATA;
  localparam logic [4:0] ST = asu_pkg::OFF_STAT;
  localparam logic [4:0] MK = asu_pkg::OFF_MASK;
  logic            core_clk, rst, ce, avs_read, avs_write;
  logic [5:0]      avs_address;
  logic [31:0]     avs_writedata, avs_readdata, q;
  logic            avs_waitrequest, irq;
  logic [1:0]      ser_txd;
  wire logic [1:0] ser_rxd;
  int              err_count, n_tests, n0;
  // rx cases: control, data, bad stop, glitch, status bit
  logic [7:0] c_ctl[4] = '{8'h03, 8'h03, 8'h03, 8'h0B};
  logic [7:0] c_dat[4] = '{8'h47, 8'h00, 8'h47, 8'h83};
  logic       c_bad[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic       c_gl[4]  = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic [6:0] c_st[4]  = '{7'h04, 7'h10, 7'h20, 7'h40};
  initial begin
    {core_clk, ce, rst, avs_read, avs_write} = 5'h0C;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    err_count = 0;
    n_tests = 0;
  end
  always #20 core_clk = ~core_clk;
  asu_top DUT (.core_clk(core_clk), .rst(rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ser_rxd(ser_rxd),
    .ser_txd(ser_txd), .irq(irq));
  // unit 1 runs at a different rate from unit 0
  asu_line_model #(.BIT(32)) PEER0 (.core_clk(core_clk), .txd(ser_txd[0]),
    .rxd(ser_rxd[0]));
  asu_line_model #(.BIT(48)) PEER1 (.core_clk(core_clk), .txd(ser_txd[1]),
    .rxd(ser_rxd[1]));
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  // waitrequest and read data are taken at the rising edge that completes
  // the access; the request drops by nonblocking assignment at that edge
  task automatic bus(input logic r, input logic u, input logic [4:0] o,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge core_clk);
    avs_address <= {u, o};
    avs_writedata <= d;
    avs_read <= r;
    avs_write <= !r;
    do begin
      @(posedge core_clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (t >= 50) chk(t, 0);
  endtask
  task automatic wr(input logic u, input logic [4:0] o, input logic [31:0] d);
    bus(1'b0, u, o, d);
  endtask
  task automatic rd(input logic u, input logic [4:0] o, input logic [31:0] m,
                    input logic [31:0] e);
    bus(1'b1, u, o, 32'h0000_0000);
    chk(q & m, e);
  endtask
  task automatic wait_tx(input int n);
    for (int t = 0; t < 3000 && PEER0.n_got != n; t++) @(posedge core_clk);
    repeat (24) @(posedge core_clk);
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(0, BD, 32'hFFFF_FFFF, 0);
    rd(1, CT, 32'hFFFF_FFFF, 0);
    rd(0, ST, 7'h7F, 0);
    wr(0, 5'h14, 32'hFFFF_FFFF);
    rd(0, 5'h14, 32'hFFFF_FFFF, 0);
    wr(1, BD, 32'hFFFF_FFFF);
    rd(1, BD, 32'hFFFF_FFFF, 13'h1FFF);
    wr(0, BD, 2);
    wr(1, BD, 3);
    wr(0, CT, 3);
    wr(1, CT, 3);
    fork
      PEER1.send(8'h96, 1'b0, 1'b0);
    join_none
    wr(0, DA, 9'h0A5);
    wr(0, DA, 9'h03C);
    wait_tx(1);
    chk(PEER0.got, 8'hA5);
    wait_tx(2);
    chk(PEER0.got, 8'h3C);
    rd(0, ST, 3, 3);
    wr(0, ST, 7'h7F);
    rd(0, ST, 3, 0);
    rd(1, ST, 11'h404, 11'h404);
    rd(1, DA, 9'h1FF, 9'h096);
    rd(1, ST, 11'h400, 0);
    wr(1, DA, 9'h05A);
    for (int t = 0; t < 3000 && PEER1.n_got != 1; t++) @(posedge core_clk);
    chk(PEER1.n_got, 1);
    chk(PEER1.got, 8'h5A);
    for (int k = 0; k < 4; k++) begin
      wr(0, CT, c_ctl[k]);
      PEER0.send(c_dat[k], c_bad[k], c_gl[k]);
      repeat (40) @(posedge core_clk);
      rd(0, ST, c_st[k], c_st[k]);
      if (k == 0) rd(0, DA, 9'h1FF, 9'h047);
      else bus(1'b1, 0, DA, 0);
      wr(0, ST, 7'h7F);
    end
    n0 = PEER0.n_got;
    wr(0, DA, 9'h001);
    wait_tx(n0 + 1);
    chk(PEER0.got, 8'h81);
    wr(0, CT, 8'h1B);
    wr(0, DA, 9'h001);
    wait_tx(n0 + 2);
    chk(PEER0.got, 8'h01);
    // peer takes 8 bits, so a high ninth bit sits where it expects the stop
    wr(0, CT, 8'h07);
    wr(0, DA, 9'h1C3);
    wait_tx(n0 + 3);
    chk(PEER0.got, 8'hC3);
    wr(0, CT, 8'h23);
    PEER0.send(8'h11, 1'b0, 1'b0);
    repeat (40) @(posedge core_clk);
    rd(0, ST, 11'h400, 0);
    PEER0.send(8'h91, 1'b0, 1'b0);
    repeat (40) @(posedge core_clk);
    rd(0, DA, 9'h1FF, 9'h091);
    wr(0, ST, 7'h7F);
    wr(0, MK, 0);
    PEER0.send(8'h22, 1'b0, 1'b0);
    repeat (40) @(posedge core_clk);
    chk(irq, 0);
    wr(0, MK, 7'h04);
    @(posedge core_clk);
    chk(irq, 1);
    bus(1'b1, 0, DA, 0);
    wr(0, ST, 7'h04);
    @(posedge core_clk);
    chk(irq, 0);
    wr(0, BD, 0);
    n0 = PEER0.n_got;
    wr(0, DA, 9'h055);
    repeat (400) @(posedge core_clk);
    chk(PEER0.n_got, n0);
    // stopped divider: the start bit is driven but never ends
    chk(ser_txd[0], 0);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(1, BD, 32'hFFFF_FFFF, 0);
    chk(ser_txd, 2'h3);
    close_out();
  end
endmodule // test_async_serial_transceiver
